// [design/wdpc_consts.svh]
/*
 * register offsets, field positions, reset values and timing counts of the
 * watchdog block. assumes nothing beyond a preprocessor.
 */
`ifndef WDPC_CONSTS_SVH
`define WDPC_CONSTS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define WDPC_IDX_RATIO      8'h09
`define WDPC_IDX_KEY_EDGE   8'h17
`define WDPC_IDX_CTRL       8'h18
`define WDPC_IDX_STATUS     8'h19
`define WDPC_IDX_IRQ_STAT   8'h1A
`define WDPC_IDX_IRQ_MASK   8'h1B

// ==========================================================
// field positions
`define WDPC_RATIO_LSB      0
`define WDPC_RATIO_MSB      2
`define WDPC_KEY_LSB        0
`define WDPC_KEY_MSB        3
`define WDPC_EDGE_LSB       6
`define WDPC_EDGE_MSB       7
`define WDPC_CTRL_CLKSEL    0
`define WDPC_STAT_TO        0
`define WDPC_STAT_PD        1
`define WDPC_STAT_ENA       2
`define WDPC_STAT_SLOW      3
`define WDPC_STAT_IDLE      4

// ==========================================================
// reset values and key codes
`define WDPC_RATIO_RST      3'h7
`define WDPC_KEY_RST        4'h0
`define WDPC_KEY_OFF        4'hA
`define WDPC_EDGE_RST       2'h2

// ==========================================================
// timing: fixed divider is 256 watchdog clocks (8 stages)
`define WDPC_FIX_STAGES     8
`define WDPC_IDIV           4

`endif

// [design/wdpc_pkg.sv]
/*
 * types of the watchdog block.
 * assumes wdpc_consts.svh for numbers.
 */
package wdpc_pkg;
	typedef enum logic [1:0] {
		WDPC_SRC_WDOSC = 2'b00,
		WDPC_SRC_RTC   = 2'b01,
		WDPC_SRC_INSTR = 2'b10
	} wdpc_src_e;

	typedef enum logic [1:0] {
		WDPC_NORMAL = 2'b00,
		WDPC_SLOW   = 2'b01,
		WDPC_IDLE   = 2'b10
	} wdpc_mode_e;

	// cpu side strobes, all one-cycle pulses on clk
	typedef struct packed {
		logic clear_single;
		logic clear_first;
		logic clear_second;
		logic halt;
	} wdpc_cpu_s;

	// reset requests towards the core
	typedef struct packed {
		logic chip_reset;
		logic warm_reset;
	} wdpc_rst_s;
endpackage

// [design/wdpc_watchdog.sv]
/*
 * watchdog with fixed divider, prescaler, clear schemes, key register,
 * edge select, clock mode control, flags, interrupt and wishbone slave.
 * assumes oscillator ticks arrive asynchronously and cpu strobes on clk.
 */
// Design decision made here: the Wishbone slave port.
// Notes on behaviour
// - watchdog clock by option: dedicated oscillator, 32768 Hz, or clk/4.
// - watchdog disabled by option makes counting, clears and resets no-ops; halt still sets power-down.
// - 32768 Hz tick usable only in internal rc plus rtc config.
// - fixed divide by 256 stage precedes prescaler.
// - prescaler select bits 2..0 give ratio two to the field.
// - overflow while running gives chip reset and sets time-out flag.
// - overflow while halted gives warm reset of pc and stack pointer only.
// - external reset low, clear sequence and halt clear counter and prescaler.
// - single clear option: every single clear instruction clears.
// - two-step option: clear only after both first and second instruction.
// - enabled if option or key enables; key 1010 disables.
// - edge select bits 7..6, reset 10: off, rise, fall, both.
// - clock mode bit picks rc (0) or 32768 Hz (1) in rtc config.
// - modes normal, slow and idle after halt.
// - dedicated oscillator keeps running in power-down unless option disables.
// - instruction clock source stops counting while halted.
// - power-down flag cleared by power-up or clear, set by halt.
`timescale 1ns/10ps
`default_nettype none
`include "wdpc_consts.svh"

module wdpc_watchdog #(
	parameter logic [1:0] WD_SRC_OPT  = 2'b00,
	parameter bit         WD_EN_OPT   = 1'b1,
	parameter bit         WD_DIS_OPT  = 1'b0,
	parameter bit         WDOSC_ON    = 1'b1,
	parameter bit         RTC_CONFIG  = 1'b1,
	parameter bit         TWO_CLEAR   = 1'b0
) (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                ce,
	input  wire logic                wdosc_tick,
	input  wire logic                rtc_tick,
	input  wire logic                external_reset_pin_b,
	input  wire logic                ext_irq_pin,
	input  wire wdpc_pkg::wdpc_cpu_s cpu,
	input  wire logic                wake,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	output wdpc_pkg::wdpc_rst_s      rst_req,
	output logic                     ext_irq_event,
	output logic                     rc_osc_run,
	output logic                     sysclk_source_sel,
	output wdpc_pkg::wdpc_mode_e     mode,
	output logic                     irq
);

	// ==========================================================
	// registers
	logic [2:0] prescale_ratio_sel;
	logic [3:0] watchdog_key_field;
	logic [1:0] ext_irq_edge_sel;
	logic       timeout_flag;
	logic       powerdown_flag;
	logic       halted;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [1:0] first_seen;
	logic       ctrl_clksel;
	logic [14:0] wd_cnt;
	logic [1:0] idiv;
	logic       wd_ena;
	logic       wd_tick;
	logic       wd_clr;
	logic       overflow;
	logic [14:0] limit;
	logic [2:0] wd_sync;
	logic [2:0] rtc_sync;
	logic [2:0] pin_sync;
	logic [2:0] rst_sync;
	logic       wd_edge;
	logic       rtc_edge;
	logic       wd_osc_lvl;
	logic       rtc_lvl;
	logic       pin_lvl;
	logic       pin_prev;
	logic       ext_rst_lvl;
	logic       bus_req;
	logic       bus_wr;
	logic [31:0] next_rdata;

	// ==========================================================
	// pin synchronisers: three stages, change counted once stages 2 and 3 agree
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wd_sync  <= 3'h0;
			rtc_sync <= 3'h0;
			pin_sync <= 3'h7;
			rst_sync <= 3'h7;
		end
		else if (ce)
		begin
			wd_sync  <= {wd_sync[1:0], wdosc_tick};
			rtc_sync <= {rtc_sync[1:0], rtc_tick};
			pin_sync <= {pin_sync[1:0], ext_irq_pin};
			rst_sync <= {rst_sync[1:0], external_reset_pin_b};
		end
	end

	// filtered levels; a disagreeing pair holds the last level
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wd_osc_lvl  <= 1'b0;
			rtc_lvl     <= 1'b0;
			pin_lvl     <= 1'b1;
			pin_prev    <= 1'b1;
			ext_rst_lvl <= 1'b1;
		end
		else if (ce)
		begin
			if (wd_sync[2] == wd_sync[1])
				wd_osc_lvl <= wd_sync[2];
			if (rtc_sync[2] == rtc_sync[1])
				rtc_lvl <= rtc_sync[2];
			if (pin_sync[2] == pin_sync[1])
				pin_lvl <= pin_sync[2];
			if (rst_sync[2] == rst_sync[1])
				ext_rst_lvl <= rst_sync[2];
			pin_prev <= pin_lvl;
		end
	end

	assign wd_edge  = wd_sync[2] && wd_sync[1] && !wd_osc_lvl;
	assign rtc_edge = rtc_sync[2] && rtc_sync[1] && !rtc_lvl;

	// ==========================================================
	// external interrupt edge detect
	always_comb
	begin
		case (ext_irq_edge_sel)
			2'b01:   ext_irq_event = pin_lvl && !pin_prev;
			2'b10:   ext_irq_event = !pin_lvl && pin_prev;
			2'b11:   ext_irq_event = pin_lvl ^ pin_prev;
			default: ext_irq_event = 1'b0;
		endcase
	end

	// ==========================================================
	// enable and clock source
	// option or key may enable; stops when both say off or the disable option is set
	assign wd_ena = !WD_DIS_OPT && (WD_EN_OPT || (watchdog_key_field != `WDPC_KEY_OFF));

	// instruction clock is clk/4; it freezes with the core while halted
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			idiv <= 2'h0;
		else if (ce && !halted)
			idiv <= idiv + 2'h1;
	end

	always_comb
	begin
		case (wdpc_pkg::wdpc_src_e'(WD_SRC_OPT))
			wdpc_pkg::WDPC_SRC_WDOSC: wd_tick = WDOSC_ON && wd_edge;
			wdpc_pkg::WDPC_SRC_RTC:   wd_tick = RTC_CONFIG && rtc_edge;
			wdpc_pkg::WDPC_SRC_INSTR: wd_tick = !halted && (idiv == 2'h3);
			default:                  wd_tick = 1'b0;
		endcase
	end

	// ==========================================================
	// clear sources
	assign wd_clr = !ext_rst_lvl || cpu.halt
		|| (!TWO_CLEAR && cpu.clear_single)
		|| (TWO_CLEAR && ((cpu.clear_second && first_seen[0]) || (cpu.clear_first && first_seen[1])));

	// bit0 first half seen, bit1 second half seen; a repeated half never completes the pair
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			first_seen <= 2'h0;
		else if (ce && wd_ena)
		begin
			if (wd_clr)
				first_seen <= 2'h0;
			else if (cpu.clear_first || cpu.clear_second)
				first_seen <= first_seen | {cpu.clear_second, cpu.clear_first};
		end
	end

	// ==========================================================
	// counter: 8 fixed stages then prescaler, one counter for both
	assign limit    = 15'((16'h0100 << prescale_ratio_sel) - 16'h0001);
	assign overflow = wd_ena && wd_tick && !wd_clr && (wd_cnt >= limit);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wd_cnt <= 15'h0000;
		else if (ce)
		begin
			if (wd_clr || overflow || !wd_ena)
				wd_cnt <= 15'h0000;
			else if (wd_tick)
				wd_cnt <= wd_cnt + 15'h0001;
		end
	end

	// reset requests to the core, one-cycle pulses
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rst_req <= '0;
		else if (ce)
		begin
			rst_req.chip_reset <= overflow && !halted;
			rst_req.warm_reset <= overflow && halted;
		end
	end

	// ==========================================================
	// halt and flags; a halted overflow (warm reset), wake or reset pin low ends idle mode
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			halted <= 1'b0;
		else if (ce)
		begin
			if (cpu.halt && wd_ena)
				halted <= 1'b1;
			else if (cpu.halt)
				halted <= 1'b1;
			else if (overflow || wake || !ext_rst_lvl)
				halted <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			timeout_flag   <= 1'b0;
			powerdown_flag <= 1'b0;
		end
		else if (ce)
		begin
			if (overflow)
				timeout_flag <= 1'b1;
			else if (cpu.halt || (wd_ena && wd_clr && ext_rst_lvl))
				timeout_flag <= 1'b0;
			if (cpu.halt)
				powerdown_flag <= 1'b1;
			else if (wd_ena && wd_clr && ext_rst_lvl)
				powerdown_flag <= 1'b0;
		end
	end

	// ==========================================================
	// clock mode outputs
	always_comb
	begin
		sysclk_source_sel = 1'b0;
		if (RTC_CONFIG)
			sysclk_source_sel = ctrl_clksel;
		if (halted)
			mode = wdpc_pkg::WDPC_IDLE;
		else if (sysclk_source_sel)
			mode = wdpc_pkg::WDPC_SLOW;
		else
			mode = wdpc_pkg::WDPC_NORMAL;
		rc_osc_run = (mode == wdpc_pkg::WDPC_NORMAL);
	end

	// ==========================================================
	// wishbone slave: ack one cycle after strobe, write lands on the edge that sees ack
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			prescale_ratio_sel <= `WDPC_RATIO_RST;
			watchdog_key_field <= `WDPC_KEY_RST;
			ext_irq_edge_sel   <= `WDPC_EDGE_RST;
			ctrl_clksel        <= 1'b0;
			irq_mask           <= 2'h0;
		end
		else if (ce && bus_wr)
		begin
			case (wb_adr_i[7:2])
				6'(`WDPC_IDX_RATIO):
					prescale_ratio_sel <= wb_dat_i[`WDPC_RATIO_MSB:`WDPC_RATIO_LSB];
				6'(`WDPC_IDX_KEY_EDGE):
				begin
					watchdog_key_field <= wb_dat_i[`WDPC_KEY_MSB:`WDPC_KEY_LSB];
					ext_irq_edge_sel   <= wb_dat_i[`WDPC_EDGE_MSB:`WDPC_EDGE_LSB];
				end
				6'(`WDPC_IDX_CTRL):
					ctrl_clksel <= wb_dat_i[`WDPC_CTRL_CLKSEL];
				6'(`WDPC_IDX_IRQ_MASK):
					irq_mask <= wb_dat_i[1:0];
				default:
					irq_mask <= irq_mask;
			endcase
		end
	end

	// sticky events: bit0 chip time-out, bit1 warm reset; set beats clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq_stat <= 2'h0;
		else if (ce)
		begin
			irq_stat <= (irq_stat & ~((bus_wr && wb_adr_i[7:2] == 6'(`WDPC_IDX_IRQ_STAT)) ? wb_dat_i[1:0] : 2'h0))
				| {rst_req.warm_reset, rst_req.chip_reset};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else if (ce)
			irq <= |(irq_stat & irq_mask);
	end

	// read mux; unmapped addresses read zero and still ack
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i[7:2])
			6'(`WDPC_IDX_RATIO):    next_rdata[2:0] = prescale_ratio_sel;
			6'(`WDPC_IDX_KEY_EDGE): next_rdata[7:0] = {ext_irq_edge_sel, 2'b00, watchdog_key_field};
			6'(`WDPC_IDX_CTRL):     next_rdata[0] = ctrl_clksel;
			6'(`WDPC_IDX_STATUS):   next_rdata[4:0] = {halted, sysclk_source_sel, wd_ena, powerdown_flag, timeout_flag};
			6'(`WDPC_IDX_IRQ_STAT): next_rdata[1:0] = irq_stat;
			6'(`WDPC_IDX_IRQ_MASK): next_rdata[1:0] = irq_mask;
			default:                next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else if (ce)
		begin
			wb_ack_o <= bus_req;
			if (bus_req)
				wb_dat_o <= next_rdata;
		end
	end

	// ==========================================================
	// checks
	a_tmo_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
		ce && overflow && !halted |=> rst_req.chip_reset && timeout_flag)
		else $error("chip time-out did not reset and flag");
	a_warm_only_halt: assert property (@(posedge clk) disable iff (!rst_b)
		rst_req.warm_reset |-> !rst_req.chip_reset && $past(halted))
		else $error("warm reset outside halt");
	a_clear_zeroes: assert property (@(posedge clk) disable iff (!rst_b)
		ce && wd_clr |=> wd_cnt == 15'h0000)
		else $error("clear did not zero counter");
	a_key_disables: assert property (@(posedge clk) disable iff (!rst_b)
		(!WD_EN_OPT && watchdog_key_field == `WDPC_KEY_OFF) |-> !wd_ena)
		else $error("key 1010 did not disable");
	a_disabled_idle: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !wd_ena |=> wd_cnt == 15'h0000 && !rst_req.chip_reset)
		else $error("disabled watchdog counted");
	a_cnt_bounded: assert property (@(posedge clk) disable iff (!rst_b)
		$stable(prescale_ratio_sel) && $past(wd_cnt) <= $past(limit) |-> wd_cnt <= limit)
		else $error("counter passed limit");
	a_halt_sets_pd: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cpu.halt |=> powerdown_flag && halted && !timeout_flag)
		else $error("halt did not set power-down");
	a_idle_rc_off: assert property (@(posedge clk) disable iff (!rst_b)
		halted |-> mode == wdpc_pkg::WDPC_IDLE && !rc_osc_run)
		else $error("idle mode wrong");
	a_edge_fall: assert property (@(posedge clk) disable iff (!rst_b)
		ext_irq_edge_sel == 2'b10 && pin_prev && !pin_lvl |-> ext_irq_event)
		else $error("falling edge missed");
	a_ack_one: assert property (@(posedge clk) disable iff (!rst_b)
		ce && wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

endmodule

`default_nettype wire

// [dv/tb_wdpc_watchdog.sv]
/*
 * self-checking bench of the watchdog block: wishbone register access,
 * edge select, time-outs, clear schemes, halt, key and interrupt.
 * assumes the design files under design/ and a 200 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_wdpc_watchdog;
	// ==========================================================
	// stimulus and bookkeeping
	logic                 clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 wdosc_tick = 1'b0;
	logic                 ext_b = 1'b1;
	logic                 ext_irq_pin = 1'b1; // pulled up, idle high
	logic                 ce = 1'b1;
	logic                 rtc_tick = 1'b0;
	logic [3:0]           wb_sel = 4'h0;
	logic                 wake = 1'b0;
	wdpc_pkg::wdpc_cpu_s  cpu = '0;
	logic                 wb_cyc = 1'b0;
	logic                 wb_stb = 1'b0;
	logic                 wb_we = 1'b0;
	logic [7:0]           wb_adr = 8'h00;
	logic [31:0]          wb_dat = 32'h0000_0000;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o;
	wdpc_pkg::wdpc_rst_s  rst_req;
	wdpc_pkg::wdpc_rst_s  rst_req2;
	logic                 ext_irq_event;
	logic                 rc_osc_run;
	logic                 sysclk_source_sel;
	wdpc_pkg::wdpc_mode_e mode;
	logic                 irq;
	logic [31:0]          q;
	int                   err_total = 0;
	int                   samples_checked = 0;
	int                   n_chip = 0;
	int                   n_warm = 0;
	int                   n_edge = 0;
	int                   n_chip2 = 0;
	int                   n_warm2 = 0;
	int                   cyc_n = 0;
	int                   base;
	int                   el;
	int                   exp_edge[4] = '{0, 1, 1, 2};

	// dedicated oscillator source, ratio register picks the prescale
	wdpc_watchdog #(
		.WD_EN_OPT  (1'b0)
	) wdpc_watchdog_inst (
		.clk                  (clk),
		.rst_b                (rst_b),
		.ce                   (ce),
		.wdosc_tick           (wdosc_tick),
		.rtc_tick             (rtc_tick),
		.external_reset_pin_b (ext_b),
		.ext_irq_pin          (ext_irq_pin),
		.cpu                  (cpu),
		.wake                 (wake),
		.wb_cyc_i             (wb_cyc),
		.wb_stb_i             (wb_stb),
		.wb_we_i              (wb_we),
		.wb_adr_i             (wb_adr),
		.wb_sel_i             (wb_sel),
		.wb_dat_i             (wb_dat),
		.wb_dat_o             (wb_dat_o),
		.wb_ack_o             (wb_ack_o),
		.rst_req              (rst_req),
		.ext_irq_event        (ext_irq_event),
		.rc_osc_run           (rc_osc_run),
		.sysclk_source_sel    (sysclk_source_sel),
		.mode                 (mode),
		.irq                  (irq)
	);

	// second copy on clk/4 with the two-step clear; shares every input, only resets watched
	wdpc_watchdog #(
		.WD_SRC_OPT (2'b10),
		.TWO_CLEAR  (1'b1)
	) wdpc_watchdog_instr_inst (
		.clk                  (clk),
		.rst_b                (rst_b),
		.ce                   (ce),
		.wdosc_tick           (wdosc_tick),
		.rtc_tick             (rtc_tick),
		.external_reset_pin_b (ext_b),
		.ext_irq_pin          (ext_irq_pin),
		.cpu                  (cpu),
		.wake                 (wake),
		.wb_cyc_i             (wb_cyc),
		.wb_stb_i             (wb_stb),
		.wb_we_i              (wb_we),
		.wb_adr_i             (wb_adr),
		.wb_sel_i             (wb_sel),
		.wb_dat_i             (wb_dat),
		.wb_dat_o             (),
		.wb_ack_o             (),
		.rst_req              (rst_req2),
		.ext_irq_event        (),
		.rc_osc_run           (),
		.sysclk_source_sel    (),
		.mode                 (),
		.irq                  ()
	);

	// ==========================================================
	// clocks: watchdog tick is eight system cycles, so 256 ticks is 2048
	always #2.5 clk = ~clk;

	always
	begin
		repeat (4) @(posedge clk);
		wdosc_tick <= ~wdosc_tick;
	end

	// slow second oscillator, not a source of either copy here
	always
	begin
		repeat (20) @(posedge clk);
		rtc_tick <= ~rtc_tick;
	end

	// event counters and hang guard, well above the ~31k cycles needed
	always @(posedge clk)
	begin
		cyc_n++;
		if (rst_req.chip_reset === 1'b1) n_chip++;
		if (rst_req.warm_reset === 1'b1) n_warm++;
		if (rst_req2.chip_reset === 1'b1) n_chip2++;
		if (rst_req2.warm_reset === 1'b1) n_warm2++;
		if (ext_irq_event === 1'b1) n_edge++;
		if (cyc_n == 60000)
		begin
			err_total++;
			wrap_up();
		end
	end

	// ==========================================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected=%h seen=%h", what, exp, seen);
			err_total++;
		end
	endtask

	// one classic cycle; request held until ack is seen at an edge
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_sel <= s;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
		wb_we  <= 1'b0;
		if (n >= 40) check("ack_wait", 32'd0, 32'd1);
	endtask

	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		cpu <= v;
		@(posedge clk);
		cpu <= '0;
	endtask

	// cycles until the next chip or warm reset request, capped at lim
	task automatic wait_rst(input bit warm, input int lim);
		int b;
		b = warm ? n_warm : n_chip;
		el = 0;
		while ((warm ? n_warm : n_chip) == b && el < lim)
		begin
			@(posedge clk);
			el++;
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(0, 8'h24, 0); check("ratio_rst", q, 32'h0000_0007);
		xfer(0, 8'h5C, 0); check("key_edge_rst", q, 32'h0000_0080);
		xfer(0, 8'h40, 0); check("unmapped", q, 32'h0000_0000);
		xfer(1, 8'h5C, 32'h0000_00F5);
		xfer(0, 8'h5C, 0); check("key_edge_rw", q, 32'h0000_00C5);
		// clock mode bit: slow stops the rc oscillator
		xfer(1, 8'h60, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check("clk_sel", {31'd0, sysclk_source_sel}, 32'd1);
		check("mode_slow", {30'd0, mode}, {30'd0, wdpc_pkg::WDPC_SLOW});
		check("rc_slow", {31'd0, rc_osc_run}, 32'd0);
		xfer(1, 8'h60, 32'h0000_0000);
		repeat (2) @(posedge clk);
		check("mode_norm", {30'd0, mode}, {30'd0, wdpc_pkg::WDPC_NORMAL});
		check("rc_norm", {31'd0, rc_osc_run}, 32'd1);
		// every edge code against one rise and one fall
		for (int e = 0; e < 4; e++)
		begin
			xfer(1, 8'h5C, {24'h0, e[1:0], 6'h05});
			base = n_edge;
			ext_irq_pin <= 1'b0;
			repeat (12) @(posedge clk);
			ext_irq_pin <= 1'b1;
			repeat (12) @(posedge clk);
			check("edge_events", n_edge - base, exp_edge[e]);
		end
		// time-out period for prescale 1:1 and 1:2
		xfer(1, 8'h6C, 32'h0000_0000);
		for (int r = 0; r < 2; r++)
		begin
			xfer(1, 8'h24, r);
			pulse(4'b1000);
			wait_rst(0, 6000);
			check("to_period", {31'd0, el >= (2048 << r) - 16 && el <= (2048 << r) + 24}, 32'd1);
		end
		xfer(0, 8'h64, 0); check("to_flag", q & 32'd1, 32'd1);
		xfer(0, 8'h68, 0); check("irq_stat", q & 32'd3, 32'd1);
		check("irq_masked", {31'd0, irq}, 32'd0);
		xfer(1, 8'h6C, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check("irq_on", {31'd0, irq}, 32'd1);
		xfer(1, 8'h68, 32'h0000_0003);
		repeat (2) @(posedge clk);
		check("irq_cleared", {31'd0, irq}, 32'd0);
		// regular single clears keep the chip alive for 7500 cycles
		xfer(1, 8'h24, 32'h0000_0000);
		// a write without byte lane 0 is ignored
		xfer(1, 8'h24, 32'h0000_0003, 4'h0);
		xfer(0, 8'h24, 0); check("sel_ignored", q, 32'h0000_0000);
		base = n_chip;
		repeat (5)
		begin
			pulse(4'b1000);
			repeat (1500) @(posedge clk);
		end
		check("alive", n_chip - base, 32'd0);
		// the two-step pair has no effect in single-clear mode
		pulse(4'b1000);
		repeat (1500) @(posedge clk);
		pulse(4'b0100);
		pulse(4'b0010);
		wait_rst(0, 1200);
		check("pair_ignored", {31'd0, el < 1200}, 32'd1);
		// reset pin restarts the count
		pulse(4'b1000);
		repeat (1500) @(posedge clk);
		ext_b <= 1'b0;
		repeat (4) @(posedge clk);
		ext_b <= 1'b1;
		base = n_chip;
		repeat (1500) @(posedge clk);
		check("pin_clear", n_chip - base, 32'd0);
		// halted overflow gives a warm reset only
		pulse(4'b1000);
		pulse(4'b0001);
		repeat (4) @(posedge clk);
		check("mode_idle", {30'd0, mode}, {30'd0, wdpc_pkg::WDPC_IDLE});
		xfer(0, 8'h64, 0); check("pd_set", q & 32'd2, 32'd2);
		base = n_chip;
		wait_rst(1, 2400);
		check("warm_seen", {31'd0, el < 2400}, 32'd1);
		check("no_chip", n_chip - base, 32'd0);
		xfer(0, 8'h64, 0); check("warm_flags", q & 32'd3, 32'd3);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (4) @(posedge clk);
		check("mode_wake", {30'd0, mode}, {30'd0, wdpc_pkg::WDPC_NORMAL});
		pulse(4'b1000);
		xfer(0, 8'h64, 0); check("pd_clr", q & 32'd2, 32'd0);
		// key 1010 stops the watchdog when the option is off
		xfer(1, 8'h5C, 32'h0000_008A);
		xfer(0, 8'h64, 0); check("ena_off", q & 32'd4, 32'd0);
		base = n_chip;
		pulse(4'b1000);
		repeat (2400) @(posedge clk);
		check("stopped", n_chip - base, 32'd0);
		xfer(1, 8'h5C, 32'h0000_0085);
		xfer(0, 8'h64, 0); check("ena_on", q & 32'd4, 32'd4);
		// clock enable low freezes the count
		pulse(4'b1000);
		base = n_chip;
		ce <= 1'b0;
		repeat (3000) @(posedge clk);
		ce <= 1'b1;
		repeat (1500) @(posedge clk);
		check("ce_freeze", n_chip - base, 32'd0);
		// two-step copy: each full pair clears, a repeated first half does not
		pulse(4'b0100);
		pulse(4'b0010);
		repeat (4) @(posedge clk);
		base = n_chip2;
		repeat (2)
		begin
			repeat (700) @(posedge clk);
			pulse(4'b0100);
			pulse(4'b0010);
		end
		repeat (700) @(posedge clk);
		check("pair_clears", n_chip2 - base, 32'd0);
		pulse(4'b0100);
		pulse(4'b0100);
		repeat (1100) @(posedge clk);
		check("first_twice", n_chip2 - base, 32'd1);
		// clk/4 copy was halted for over 2000 cycles and never timed out
		check("instr_halt", n_warm2, 32'd0);
		wrap_up();
	end
endmodule

`default_nettype wire
